/* hw/viru_arb.sv */
// Priority selector for one interrupt target: picks the highest priority
// eligible input, lowest index on ties.
// Assumes all inputs are synchronous to clk; purely combinational.
`timescale 1ns/1ps
module viru_arb #(
    parameter int N = 56,
    parameter int PW = 4,
    parameter int IW = 6
) (
    // Assertion clocking only
    input wire logic clk,
    input wire logic arst_n,
    // Request state
    input wire logic [N-1:0] active,
    input wire logic [N-1:0][PW-1:0] prio,
    input wire logic [N-1:0] tgt,
    input wire logic sel,
    input wire logic [PW-1:0] thr,
    // Result
    output logic [N-1:0] elig,
    output logic hit,
    output logic [IW-1:0] idx,
    output logic [PW-1:0] best
);
    logic [N-1:0] geq;
    logic [N-1:0] gt;
    logic [N-1:0] below;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            // Strictly above threshold, so priority zero can never pass
            assign elig[g] = active[g] && (tgt[g] == sel) && (prio[g] > thr);
            assign geq[g] = elig[g] && (prio[g] >= best);
            assign gt[g] = elig[g] && (prio[g] > best);
            assign below[g] = (IW'(g) < idx);
        end
    endgenerate

    // Descending scan with >= lets the lowest index win a tie
    always_comb begin
        hit = 1'b0;
        idx = '0;
        best = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (elig[i] && (!hit || prio[i] >= best)) begin
                hit = 1'b1;
                idx = IW'(i);
                best = prio[i];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_winner_is_max: assert property (hit |-> gt == '0)
        else $error("selected priority is not the highest eligible");
    a_lowest_index_tie: assert property (hit |-> (geq & below) == '0)
        else $error("a lower index of equal priority was passed over");
endmodule // viru_arb

/* hw/viru_pkg.sv */
// Shared constants for the vectored interrupt router: sizes, register map,
// field positions and reset values.
// Assumes a 32-bit register port with word-aligned byte addresses.
package viru_pkg;

    // Sizes
    localparam int NUM_IN = 56;
    localparam int PRIO_W = 4;
    localparam int IDX_W = 6;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [11:0] THR_FAST_ADDR = 12'h000;
    localparam logic [11:0] THR_STD_ADDR = 12'h004;
    localparam logic [11:0] VEC_FAST_ADDR = 12'h008;
    localparam logic [11:0] VEC_STD_ADDR = 12'h00c;
    localparam logic [11:0] RAW_LO_ADDR = 12'h010;
    localparam logic [11:0] RAW_HI_ADDR = 12'h014;
    localparam logic [11:0] EVT_STAT_ADDR = 12'h018;
    localparam logic [11:0] EVT_MASK_ADDR = 12'h01c;
    localparam logic [11:0] CFG_BASE_ADDR = 12'h100;

    // Per-input configuration word fields
    localparam int CFG_PRIO_LSB = 0;
    localparam int CFG_TGT_BIT = 8;
    localparam int CFG_POL_BIT = 16;
    localparam int CFG_SWR_BIT = 24;
    localparam int CFG_RAW_BIT = 28;

    // Vector word fields
    localparam int VEC_IDX_LSB = 0;
    localparam int VEC_PRIO_LSB = 8;
    localparam int VEC_VALID_BIT = 31;

    // Event status bits
    localparam int EVT_FAST_BIT = 0;
    localparam int EVT_STD_BIT = 1;

    // Reset values
    localparam logic [3:0] THR_RST = 4'h0;
    localparam logic [3:0] PRIO_RST = 4'h0;
    localparam logic [1:0] EVT_MASK_RST = 2'h0;

    typedef enum logic {
        TGT_FAST = 1'b0,
        TGT_STD = 1'b1
    } viru_target_e;

endpackage

/* hw/viru_router.sv */
// Vectored interrupt router: 56 level requests, per-input polarity,
// priority, target and software request, two targets with thresholds.
// Assumes CLK is the gated interrupt unit branch clock and ARST_N is the
// interrupt unit reset from the warm-reset tree; REQ pins are asynchronous.
//
// Summary of operation
// - Requests are level sensitive; per-input polarity bit picks active high or low.
// - Fifty-six request inputs, each with its own configuration word.
// - Software request bit per input is ORed in after the synchroniser and polarity, then masked like a hardware request.
// - Software can read each request's raw state before priority masking.
// - Target bit 0 routes to fast interrupt, 1 to standard interrupt.
// - Masking is per target, comparing priority against that target's threshold.
// - Four-bit priority per input; zero never interrupts, fifteen is highest.
// - Each target presents a vector naming its winning pending request.
// - A higher priority request interrupts a lower one being served.
// - All sequential logic runs on the gated interrupt unit branch clock.
// - Logic is reset by the interrupt unit reset from the warm-reset tree.
`timescale 1ns/1ps
module viru_router #(
    parameter int N = viru_pkg::NUM_IN
) (
    // Branch clock and unit reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Request pins
    input wire logic [N-1:0] REQ,
    // Register port
    input wire logic [viru_pkg::ADDR_W-1:0] ADDR,
    input wire logic [viru_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [viru_pkg::DATA_W-1:0] RDATA,
    // Processor side
    output logic FAST_INTERRUPT_REQUEST,
    output logic STD_INTERRUPT_REQUEST,
    output logic [viru_pkg::IDX_W-1:0] FAST_VECTOR,
    output logic [viru_pkg::IDX_W-1:0] STD_VECTOR,
    // Event interrupt
    output logic EVT_IRQ
);
    localparam int PW = viru_pkg::PRIO_W;
    localparam int IW = viru_pkg::IDX_W;
    localparam int DW = viru_pkg::DATA_W;
    localparam int AW = viru_pkg::ADDR_W;

    typedef struct packed {
        logic [N-1:0][PW-1:0] prio;
        logic [N-1:0] tgt;
        logic [N-1:0] pol;
        logic [N-1:0] swr;
        logic [PW-1:0] thr_fast;
        logic [PW-1:0] thr_std;
        logic [1:0] evt;
        logic [1:0] mask;
        logic fast;
        logic std;
        logic [IW-1:0] fast_idx;
        logic [IW-1:0] std_idx;
        logic [PW-1:0] fast_prio;
        logic [PW-1:0] std_prio;
        logic [DW-1:0] rdata;
    } viru_state_s;

    viru_state_s q, d;

    logic [N-1:0] sreq;
    logic [N-1:0] raw;
    logic [N-1:0] elig_f;
    logic [N-1:0] elig_s;
    logic hit_f;
    logic hit_s;
    logic [IW-1:0] idx_f;
    logic [IW-1:0] idx_s;
    logic [PW-1:0] prio_f;
    logic [PW-1:0] prio_s;
    logic [DW-1:0] raw_lo;
    logic [DW-1:0] raw_hi;
    logic [AW-3:0] cfg_word;
    logic cfg_hit;
    logic [IW-1:0] cfg_idx;
    logic [PW-1:0] wd_prio;
    logic tgt_of_f;
    logic tgt_of_s;

    viru_sync #(
        .W(N)
    ) u_sync (
        .clk(CLK),
        .arst_n(ARST_N),
        .din(REQ),
        .dout(sreq)
    );

    // Polarity bit set means the pin is active low; software requests are
    // merged before masking so they follow the exact same path
    assign raw = (sreq ^ q.pol) | q.swr;

    viru_arb #(
        .N(N),
        .PW(PW),
        .IW(IW)
    ) u_arb_fast (
        .clk(CLK),
        .arst_n(ARST_N),
        .active(raw),
        .prio(q.prio),
        .tgt(q.tgt),
        .sel(viru_pkg::TGT_FAST),
        .thr(q.thr_fast),
        .elig(elig_f),
        .hit(hit_f),
        .idx(idx_f),
        .best(prio_f)
    );

    viru_arb #(
        .N(N),
        .PW(PW),
        .IW(IW)
    ) u_arb_std (
        .clk(CLK),
        .arst_n(ARST_N),
        .active(raw),
        .prio(q.prio),
        .tgt(q.tgt),
        .sel(viru_pkg::TGT_STD),
        .thr(q.thr_std),
        .elig(elig_s),
        .hit(hit_s),
        .idx(idx_s),
        .best(prio_s)
    );

    // Upper raw word carries the inputs above bit 31, zero filled
    assign raw_lo = raw[DW-1:0];
    assign raw_hi = {{(2 * DW - N){1'b0}}, raw[N-1:DW]};
    assign wd_prio = WDATA[PW-1:0];
    assign tgt_of_f = q.tgt[idx_f];
    assign tgt_of_s = q.tgt[idx_s];

    // Configuration words sit one per input from the base address upward
    // ADDR[1:0] are not decoded, so a sub-word address aliases its word
    assign cfg_word = ADDR[AW-1:2] - viru_pkg::CFG_BASE_ADDR[AW-1:2];
    assign cfg_hit = (ADDR >= viru_pkg::CFG_BASE_ADDR) && (cfg_word < (AW - 2)'(N));
    assign cfg_idx = cfg_word[IW-1:0];

    always_comb begin
        d = q;
        d.rdata = '0;

        // Register writes
        // Read-only words fall to the default arm, so writes to them are dropped
        if (WR) begin
            if (cfg_hit) begin
                d.prio[cfg_idx] = WDATA[viru_pkg::CFG_PRIO_LSB +: PW];
                d.tgt[cfg_idx] = WDATA[viru_pkg::CFG_TGT_BIT];
                d.pol[cfg_idx] = WDATA[viru_pkg::CFG_POL_BIT];
                d.swr[cfg_idx] = WDATA[viru_pkg::CFG_SWR_BIT];
            end else begin
                case (ADDR)
                    viru_pkg::THR_FAST_ADDR: d.thr_fast = wd_prio;
                    viru_pkg::THR_STD_ADDR: d.thr_std = wd_prio;
                    viru_pkg::EVT_MASK_ADDR: d.mask = WDATA[1:0];
                    default: ;
                endcase
            end
        end

        // Register reads; unmapped addresses return zero
        if (RD) begin
            if (cfg_hit) begin
                d.rdata[viru_pkg::CFG_PRIO_LSB +: PW] = q.prio[cfg_idx];
                d.rdata[viru_pkg::CFG_TGT_BIT] = q.tgt[cfg_idx];
                d.rdata[viru_pkg::CFG_POL_BIT] = q.pol[cfg_idx];
                d.rdata[viru_pkg::CFG_SWR_BIT] = q.swr[cfg_idx];
                d.rdata[viru_pkg::CFG_RAW_BIT] = raw[cfg_idx];
            end else begin
                case (ADDR)
                    viru_pkg::THR_FAST_ADDR: d.rdata[PW-1:0] = q.thr_fast;
                    viru_pkg::THR_STD_ADDR: d.rdata[PW-1:0] = q.thr_std;
                    viru_pkg::VEC_FAST_ADDR: begin
                        d.rdata[viru_pkg::VEC_IDX_LSB +: IW] = q.fast_idx;
                        d.rdata[viru_pkg::VEC_PRIO_LSB +: PW] = q.fast_prio;
                        d.rdata[viru_pkg::VEC_VALID_BIT] = q.fast;
                    end
                    viru_pkg::VEC_STD_ADDR: begin
                        d.rdata[viru_pkg::VEC_IDX_LSB +: IW] = q.std_idx;
                        d.rdata[viru_pkg::VEC_PRIO_LSB +: PW] = q.std_prio;
                        d.rdata[viru_pkg::VEC_VALID_BIT] = q.std;
                    end
                    viru_pkg::RAW_LO_ADDR: d.rdata = raw_lo;
                    viru_pkg::RAW_HI_ADDR: d.rdata = raw_hi;
                    viru_pkg::EVT_STAT_ADDR: d.rdata[1:0] = q.evt;
                    viru_pkg::EVT_MASK_ADDR: d.rdata[1:0] = q.mask;
                    default: d.rdata = '0;
                endcase
            end
        end

        // Target outputs and vectors. Nesting works because the service
        // routine raises the threshold to the priority it serves; only a
        // strictly higher request then reasserts the line.
        d.fast = hit_f;
        d.std = hit_s;
        d.fast_idx = hit_f ? idx_f : q.fast_idx;
        d.std_idx = hit_s ? idx_s : q.std_idx;
        d.fast_prio = hit_f ? prio_f : '0;
        d.std_prio = hit_s ? prio_s : '0;

        // Sticky rise events; a set in the clearing cycle wins
        if (WR && ADDR == viru_pkg::EVT_STAT_ADDR) begin
            d.evt = q.evt & ~WDATA[1:0];
        end
        if (hit_f && !q.fast) begin
            d.evt[viru_pkg::EVT_FAST_BIT] = 1'b1;
        end
        if (hit_s && !q.std) begin
            d.evt[viru_pkg::EVT_STD_BIT] = 1'b1;
        end
    end

    // Priorities reset to zero so every input starts masked
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= '0;
            q.thr_fast <= viru_pkg::THR_RST;
            q.thr_std <= viru_pkg::THR_RST;
            q.mask <= viru_pkg::EVT_MASK_RST;
            q.prio <= {N{viru_pkg::PRIO_RST}};
        end else begin
            q <= d;
        end
    end

    assign RDATA = q.rdata;
    assign FAST_INTERRUPT_REQUEST = q.fast;
    assign STD_INTERRUPT_REQUEST = q.std;
    assign FAST_VECTOR = q.fast_idx;
    assign STD_VECTOR = q.std_idx;
    assign EVT_IRQ = |(q.evt & q.mask);

    // Checks below look at registered outputs one edge after their cause, and at arbiter results in their own cycle
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_zero_prio_masked: assert property (FAST_INTERRUPT_REQUEST |-> q.fast_prio != '0)
        else $error("fast output raised with priority zero");
    a_fast_above_thresh: assert property (
        FAST_INTERRUPT_REQUEST |-> q.fast_prio > $past(q.thr_fast))
        else $error("fast output raised at or below threshold");
    a_target_route_fast: assert property (hit_f |-> tgt_of_f == viru_pkg::TGT_FAST)
        else $error("fast winner not routed to fast target");
    a_target_route_std: assert property (hit_s |-> tgt_of_s == viru_pkg::TGT_STD)
        else $error("standard winner not routed to standard target");
    a_sw_request_raw: assert property ((q.swr != '0) |-> (raw & q.swr) == q.swr)
        else $error("software request missing from raw state");
    a_raw_read_value: assert property (
        (RD && ADDR == viru_pkg::RAW_LO_ADDR) |=> RDATA == $past(raw_lo))
        else $error("raw state read returned wrong value");
    a_nest_reassert: assert property ((|elig_s) |=> STD_INTERRUPT_REQUEST ##0
        STD_VECTOR == $past(idx_s))
        else $error("eligible request did not reach standard output");
    a_thresh_write: assert property (
        (WR && ADDR == viru_pkg::THR_STD_ADDR) |=> q.thr_std == $past(wd_prio))
        else $error("standard threshold write not taken");
    a_event_sticky: assert property ($rose(q.fast) |-> q.evt[viru_pkg::EVT_FAST_BIT])
        else $error("fast rise did not set its event bit");
    a_read_one_cycle: assert property (!$past(RD) |-> RDATA == '0)
        else $error("read data outside the answer cycle");

    // Target lines and vectors against the arbiters
    a_zero_prio_std: assert property (STD_INTERRUPT_REQUEST |-> q.std_prio != '0)
        else $error("standard output raised with priority zero");
    a_std_above_thresh: assert property (
        STD_INTERRUPT_REQUEST |-> q.std_prio > $past(q.thr_std))
        else $error("standard output raised at or below threshold");
    a_all_masked_quiet: assert property ((q.prio == '0) |=>
        !FAST_INTERRUPT_REQUEST && !STD_INTERRUPT_REQUEST)
        else $error("a line rose while every priority was zero");
    a_fast_follows: assert property ((|elig_f) |=> FAST_INTERRUPT_REQUEST ##0
        FAST_VECTOR == $past(idx_f))
        else $error("eligible request did not reach fast output");
    a_std_line_drops: assert property (!(|elig_s) |=> !STD_INTERRUPT_REQUEST)
        else $error("standard output held with nothing eligible");
    a_fast_line_drops: assert property (!(|elig_f) |=> !FAST_INTERRUPT_REQUEST)
        else $error("fast output held with nothing eligible");

    // Register port against the state it reports
    a_vec_read_fast: assert property (
        (RD && ADDR == viru_pkg::VEC_FAST_ADDR) |=>
        RDATA[viru_pkg::VEC_IDX_LSB +: IW] == $past(FAST_VECTOR) &&
        RDATA[viru_pkg::VEC_PRIO_LSB +: PW] == $past(q.fast_prio) &&
        RDATA[viru_pkg::VEC_VALID_BIT] == $past(FAST_INTERRUPT_REQUEST))
        else $error("fast vector read returned wrong value");
    a_vec_read_std: assert property (
        (RD && ADDR == viru_pkg::VEC_STD_ADDR) |=>
        RDATA[viru_pkg::VEC_IDX_LSB +: IW] == $past(STD_VECTOR) &&
        RDATA[viru_pkg::VEC_PRIO_LSB +: PW] == $past(q.std_prio) &&
        RDATA[viru_pkg::VEC_VALID_BIT] == $past(STD_INTERRUPT_REQUEST))
        else $error("standard vector read returned wrong value");
    a_raw_hi_read: assert property (
        (RD && ADDR == viru_pkg::RAW_HI_ADDR) |=> RDATA == $past(raw_hi))
        else $error("upper raw state read returned wrong value");
    a_raw_cfg_read: assert property (
        (RD && cfg_hit) |=> RDATA[viru_pkg::CFG_RAW_BIT] == $past(raw[cfg_idx]))
        else $error("raw bit of a configuration read returned wrong value");
    a_thresh_read_std: assert property (
        (RD && ADDR == viru_pkg::THR_STD_ADDR) |=> RDATA[PW-1:0] == $past(q.thr_std))
        else $error("standard threshold read returned wrong value");
    a_thresh_write_fast: assert property (
        (WR && ADDR == viru_pkg::THR_FAST_ADDR) |=> q.thr_fast == $past(wd_prio))
        else $error("fast threshold write not taken");
    a_prio_write: assert property (
        (WR && cfg_hit) |=> q.prio[$past(cfg_idx)] == $past(WDATA[viru_pkg::CFG_PRIO_LSB +: PW]))
        else $error("priority write not taken");
    a_route_write: assert property (
        (WR && cfg_hit) |=> q.tgt[$past(cfg_idx)] == $past(WDATA[viru_pkg::CFG_TGT_BIT]))
        else $error("target write not taken");
    a_pol_write: assert property (
        (WR && cfg_hit) |=> q.pol[$past(cfg_idx)] == $past(WDATA[viru_pkg::CFG_POL_BIT]))
        else $error("polarity write not taken");
    a_swr_write: assert property (
        (WR && cfg_hit) |=> q.swr[$past(cfg_idx)] == $past(WDATA[viru_pkg::CFG_SWR_BIT]))
        else $error("software request write not taken");
    a_mask_write: assert property (
        (WR && ADDR == viru_pkg::EVT_MASK_ADDR) |=> q.mask == $past(WDATA[1:0]))
        else $error("event mask write not taken");
    a_event_clear: assert property (
        (WR && ADDR == viru_pkg::EVT_STAT_ADDR && !(hit_f && !q.fast) && !(hit_s && !q.std))
        |=> (q.evt & $past(WDATA[1:0])) == 2'b00)
        else $error("written event bits did not clear");
    a_event_sticky_std: assert property ($rose(q.std) |-> q.evt[viru_pkg::EVT_STD_BIT])
        else $error("standard rise did not set its event bit");

    c_fast_taken: cover property ($rose(FAST_INTERRUPT_REQUEST));
    c_std_taken: cover property ($rose(STD_INTERRUPT_REQUEST));
    c_preempt: cover property (STD_INTERRUPT_REQUEST && $past(STD_INTERRUPT_REQUEST)
        && q.std_prio > $past(q.std_prio));
    c_sw_request: cover property ($rose(|q.swr) ##1 STD_INTERRUPT_REQUEST);
    c_event_irq: cover property ($rose(EVT_IRQ));
endmodule // viru_router

/* hw/viru_sync.sv */
// Two-flop synchroniser for a vector of level inputs.
// Assumes each bit is an independent slow level; no bus coherence.
`timescale 1ns/1ps
module viru_sync #(
    parameter int W = 56
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } viru_sync_s;

    viru_sync_s q, d;

    // The first stage feeds only the second stage
    always_comb begin
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule // viru_sync

/* verif/viru_core_model.sv */
// Processor core stand-in: watches both interrupt lines and the standard vector.
// Assumes lines and vectors are registered on the rising edge of clk.
`timescale 1ns/1ps
module viru_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Interrupt lines and vectors
    input wire logic fast_line,
    input wire logic std_line,
    input wire logic [5:0] fast_vec,
    input wire logic [5:0] std_vec,
    // Observations
    output logic [7:0] fast_cnt,
    output logic [7:0] std_cnt,
    output logic [5:0] std_taken
);
    logic fast_prev;
    logic std_prev;

    // The core takes an exception on each rising line; a standard rise also reads the standard vector at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fast_prev <= 1'b0;
            std_prev <= 1'b0;
            fast_cnt <= 8'h00;
            std_cnt <= 8'h00;
            std_taken <= 6'h00;
        end else begin
            fast_prev <= fast_line;
            std_prev <= std_line;
            if (fast_line && !fast_prev) begin
                fast_cnt <= fast_cnt + 8'h01;
            end
            if (std_line && !std_prev) begin
                std_cnt <= std_cnt + 8'h01;
                std_taken <= std_vec;
            end
        end
    end
endmodule // viru_core_model

/* verif/viru_router_test.sv */
// Self-checking bench for the vectored interrupt router.
// Assumes the register map and field layout of viru_pkg.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end \
end
module viru_router_test;
    typedef struct {
        logic [5:0] n;
        logic [3:0] prio;
        logic tgt, pol, swr, req;
        logic [3:0] tf, ts;
        logic ef, es, raw;
    } viru_row_s;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [55:0] req = '0;
    logic [11:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic fast_irq, std_irq, evt_irq;
    logic [5:0] fast_vec, std_vec, std_taken;
    logic [7:0] fast_cnt, std_cnt, cnt0;
    logic [31:0] d;
    int mismatches = 0;
    int tests_run = 0;
    viru_row_s rows [9] = '{
        '{0, 1, 0, 0, 0, 1, 0, 0, 1, 0, 1},   // Lowest priority passes
        '{55, 15, 1, 0, 0, 1, 0, 0, 0, 1, 1}, // Last input
        '{10, 5, 1, 1, 0, 0, 0, 0, 0, 1, 1},  // Active low
        '{10, 5, 1, 1, 0, 1, 0, 0, 0, 0, 0},  // Active low idle
        '{20, 0, 0, 0, 1, 0, 0, 0, 0, 0, 1},  // Priority zero masked
        '{20, 3, 0, 0, 1, 0, 0, 0, 1, 0, 1},  // Software request
        '{30, 4, 0, 0, 0, 1, 4, 0, 0, 0, 1},  // Equal to threshold
        '{30, 5, 0, 0, 0, 1, 4, 0, 1, 0, 1},  // One above threshold
        '{31, 4, 1, 0, 0, 1, 15, 3, 0, 1, 1}  // Thresholds per target
    };

    always #4 clk = ~clk;

    viru_router viru_router_i (
        .CLK(clk), .ARST_N(arst_n), .REQ(req), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .FAST_INTERRUPT_REQUEST(fast_irq),
        .STD_INTERRUPT_REQUEST(std_irq), .FAST_VECTOR(fast_vec),
        .STD_VECTOR(std_vec), .EVT_IRQ(evt_irq)
    );

    viru_core_model viru_core_model_i (
        .clk(clk), .arst_n(arst_n), .fast_line(fast_irq), .std_line(std_irq),
        .fast_vec(fast_vec), .std_vec(std_vec), .fast_cnt(fast_cnt),
        .std_cnt(std_cnt), .std_taken(std_taken)
    );

    function automatic logic [11:0] cfg_addr(input logic [5:0] n);
        return viru_pkg::CFG_BASE_ADDR + {4'h0, n, 2'h0};
    endfunction

    function automatic logic [31:0] cfg_word(input logic [3:0] p, input logic t, pl, s);
        return (32'(p) << viru_pkg::CFG_PRIO_LSB) | (32'(t) << viru_pkg::CFG_TGT_BIT)
            | (32'(pl) << viru_pkg::CFG_POL_BIT) | (32'(s) << viru_pkg::CFG_SWR_BIT);
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(viru_pkg::THR_FAST_ADDR, {28'h0, rows[i].tf});
            wr(viru_pkg::THR_STD_ADDR, {28'h0, rows[i].ts});
            req[rows[i].n] <= rows[i].req;
            wr(cfg_addr(rows[i].n), cfg_word(rows[i].prio, rows[i].tgt, rows[i].pol, rows[i].swr));
            repeat (4) @(posedge clk);
            #1;
            `CHK(fast_irq, rows[i].ef)
            `CHK(std_irq, rows[i].es)
            if (rows[i].ef) `CHK(fast_vec, rows[i].n)
            if (rows[i].es) `CHK(std_vec, rows[i].n)
            rd(cfg_addr(rows[i].n), d);
            `CHK(d[viru_pkg::CFG_RAW_BIT], rows[i].raw)
            wr(cfg_addr(rows[i].n), 32'h0);
            req[rows[i].n] <= 1'b0;
        end
        `CHK(fast_cnt, 8'd3)
        rd(viru_pkg::VEC_FAST_ADDR, d);
        `CHK(d, 32'h0000_001e)
        // Equal priorities, event status and mask
        wr(viru_pkg::THR_FAST_ADDR, 32'h0);
        wr(viru_pkg::THR_STD_ADDR, 32'h0);
        wr(viru_pkg::EVT_STAT_ADDR, 32'h3);
        wr(viru_pkg::EVT_MASK_ADDR, 32'h2);
        wr(cfg_addr(6'd7), cfg_word(4'h6, 1'b1, 1'b0, 1'b1));
        wr(cfg_addr(6'd3), cfg_word(4'h6, 1'b1, 1'b0, 1'b1));
        repeat (3) @(posedge clk);
        #1;
        `CHK(std_vec, 6'd3)
        `CHK(evt_irq, 1'b1)
        rd(viru_pkg::VEC_STD_ADDR, d);
        `CHK(d, 32'h8000_0603)
        // Serving level 6: only a strictly higher request may nest
        wr(viru_pkg::THR_STD_ADDR, 32'h6);
        repeat (3) @(posedge clk);
        #1;
        `CHK(std_irq, 1'b0)
        cnt0 = std_cnt;
        wr(cfg_addr(6'd41), cfg_word(4'h9, 1'b1, 1'b0, 1'b1));
        repeat (3) @(posedge clk);
        #1;
        `CHK(std_irq, 1'b1)
        `CHK(std_cnt, cnt0 + 8'h01)
        `CHK(std_taken, 6'd41)
        rd(viru_pkg::RAW_HI_ADDR, d);
        `CHK(d, 32'h0000_0200)
        rd(viru_pkg::RAW_LO_ADDR, d);
        `CHK(d, 32'h0000_0088)
        wr(viru_pkg::EVT_STAT_ADDR, 32'h2);
        repeat (2) @(posedge clk);
        #1;
        `CHK(evt_irq, 1'b0)
        rd(viru_pkg::EVT_STAT_ADDR, d);
        `CHK(d, 32'h0)
        // Reset in mid-run clears configuration and lines
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(std_irq, 1'b0)
        `CHK(rdata, 32'h0)
        @(posedge clk);
        arst_n <= 1'b1;
        rd(cfg_addr(6'd41), d);
        `CHK(d, 32'h0)
        rd(viru_pkg::THR_STD_ADDR, d);
        `CHK(d, 32'h0)
        rd(12'h080, d);
        `CHK(d, 32'h0)
        finish_test();
    end
endmodule // viru_router_test
